// file: rtl/dmc_drive.sv
// Drive mode controller: torque, clock-direction and auto setup command handling
//
`timescale 1ns/1ps
module dmc_drive #(
  parameter int POS_W = 32,
  parameter int TIME_BASE_CYC = dmc_pkg::TIME_BASE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pulse link
  dmc_link_if.drive link,
  // Configuration
  input wire logic [7:0] mode_i,
  input wire logic [15:0] control_word_i,
  input wire logic subtype_i,
  input wire logic closed_loop_req_i,
  input wire logic [15:0] step_num_i,
  input wire logic [15:0] step_den_i,
  input wire logic [7:0] pole_pairs_i,
  input wire logic [7:0] cycle_period_i,
  input wire logic signed [7:0] time_index_i,
  input wire logic [15:0] max_torque_i,
  // Cyclic torque setpoint strobe
  input wire logic torque_wr_i,
  input wire logic signed [15:0] torque_i,
  // Feedback
  input wire logic signed [POS_W-1:0] actual_pos_i,
  input wire logic [POS_W-1:0] follow_window_i,
  input wire logic [15:0] follow_timeout_ms_i,
  input wire logic index_i,
  input wire logic limit_neg_i,
  input wire logic limit_pos_i,
  // Outputs
  output logic [15:0] status_word_o,
  output logic signed [POS_W-1:0] demand_pos_o,
  output logic signed [15:0] torque_cmd_o,
  output logic closed_loop_o,
  output logic [15:0] full_steps_rev_o
);
  typedef enum logic [1:0] {SETUP_IDLE, SETUP_RUN, SETUP_DONE} dmc_setup_t;
  typedef struct packed {
    dmc_setup_t setup;
    logic [15:0] setup_cnt;
    logic aligned;
    logic indexed;
    logic start_prev;
    logic [31:0] tick_cnt;
    logic [7:0] ms_cnt;
    logic [7:0] cyc_ms;
    logic written;
    logic sync;
    logic follow;
    logic [15:0] err_ms;
    logic follow_err;
    logic [15:0] frac;
    logic signed [POS_W-1:0] pos;
    logic signed [15:0] torque;
    logic [15:0] status;
    logic [15:0] fsr;
    logic closed_loop;
  } dmc_state_t;
  dmc_state_t st_q, st_d;

  logic [1:0] raw_rise;
  logic [1:0] raw_lvl;
  logic idx_rise;
  logic lim_neg_s;
  logic lim_pos_s;

  // Synchronise both pulse pins and the index pin
  dmc_edge_sync u_sync_step (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(link.step),
    .level_o(raw_lvl[0]), .rise_o(raw_rise[0]));
  dmc_edge_sync u_sync_dir (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(link.dir),
    .level_o(raw_lvl[1]), .rise_o(raw_rise[1]));
  dmc_edge_sync u_sync_idx (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(index_i),
    .level_o(), .rise_o(idx_rise));
  // Limit switch pins are asynchronous too; two stages before any logic reads them
  dmc_edge_sync u_sync_lneg (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(limit_neg_i),
    .level_o(lim_neg_s), .rise_o());
  dmc_edge_sync u_sync_lpos (.clk_i(clk_i), .rst_n_i(rst_n_i), .async_i(limit_pos_i),
    .level_o(lim_pos_s), .rise_o());

  // Absolute difference, used for the following error check
  function automatic logic [POS_W-1:0] absdiff(input logic signed [POS_W-1:0] a,
                                               input logic signed [POS_W-1:0] b);
    logic signed [POS_W-1:0] d;
    d = a - b;
    absdiff = d[POS_W-1] ? POS_W'(-d) : d;
  endfunction

  logic [31:0] sum;
  logic [15:0] whole;
  logic step_ev;
  logic step_up;
  logic ms_tick;
  logic limit_hit;

  always_comb begin
    st_d = st_q;
    sum = 32'h0;
    whole = 16'h0;
    step_ev = 1'b0;
    step_up = 1'b0;
    limit_hit = 1'b0;
    // 1 ms time base
    ms_tick = (st_q.tick_cnt == 32'(TIME_BASE_CYC - 1));
    st_d.tick_cnt = ms_tick ? 32'h0 : st_q.tick_cnt + 32'h1;

    // Auto setup run; start only on a control word bit rise
    st_d.start_prev = control_word_i[dmc_pkg::CW_START];
    unique case (st_q.setup)
      SETUP_IDLE, SETUP_DONE: begin
        if (mode_i == dmc_pkg::MODE_AUTO_SETUP && control_word_i[dmc_pkg::CW_START] &&
            !st_q.start_prev) begin
          st_d.setup = SETUP_RUN;
          st_d.setup_cnt = 16'h0;
          st_d.indexed = 1'b0;
        end
      end
      SETUP_RUN: begin
        if (idx_rise) begin
          st_d.indexed = 1'b1;
        end
        st_d.setup_cnt = st_q.setup_cnt + 16'h1;
        if (st_q.setup_cnt == 16'(dmc_pkg::SETUP_RUN_CYC - 1)) begin
          st_d.setup = SETUP_DONE;
          st_d.aligned = 1'b1;
        end
      end
      default: st_d.setup = SETUP_IDLE;
    endcase

    // Cycle time in ms only when the time index is the supported one
    st_d.cyc_ms = (time_index_i == dmc_pkg::TIME_INDEX_MS) ? cycle_period_i : 8'h0;
    if (torque_wr_i) begin
      st_d.written = 1'b1;
    end
    if (ms_tick) begin
      if (st_q.ms_cnt + 8'h1 >= st_q.cyc_ms) begin
        st_d.ms_cnt = 8'h0;
        st_d.sync = st_q.written && st_q.cyc_ms != 8'h0;
        st_d.written = torque_wr_i;
      end else begin
        st_d.ms_cnt = st_q.ms_cnt + 8'h1;
      end
    end

    // Torque mode: setpoint used only under closed loop, control word not read here
    st_d.follow = (mode_i == dmc_pkg::MODE_CST) && st_q.aligned && closed_loop_req_i;
    if (st_q.follow && torque_wr_i) begin
      if (torque_i > $signed({1'b0, max_torque_i[14:0]})) begin
        st_d.torque = $signed({1'b0, max_torque_i[14:0]});
      end else if (torque_i < -$signed({1'b0, max_torque_i[14:0]})) begin
        st_d.torque = -$signed({1'b0, max_torque_i[14:0]});
      end else begin
        st_d.torque = torque_i;
      end
    end else if (!st_q.follow) begin
      st_d.torque = 16'sh0;
    end

    // Pulse decoding by subtype
    if (subtype_i == dmc_pkg::step_dir_subtype) begin
      step_ev = raw_rise[0];
      step_up = raw_lvl[1];
    end else begin
      step_ev = raw_rise[0] ^ raw_rise[1];
      step_up = raw_rise[0];
    end
    // Limit switches stay live: a step into a tripped switch is dropped
    limit_hit = (step_up && lim_pos_s) || (!step_up && lim_neg_s);
    if (mode_i == dmc_pkg::MODE_STEP_DIR && step_ev && !limit_hit) begin
      // Step in full-step/512 units: add num, carry whole units per denominator
      sum = 32'(st_q.frac) + 32'(step_num_i);
      if (step_den_i > 16'h1) begin
        whole = 16'(sum / 32'(step_den_i));
        st_d.frac = 16'(sum % 32'(step_den_i));
      end else begin
        whole = sum[15:0];
        st_d.frac = 16'h0;
      end
      st_d.pos = step_up ? st_q.pos + POS_W'(whole) : st_q.pos - POS_W'(whole);
    end
    st_d.fsr = 16'(pole_pairs_i) * 16'(dmc_pkg::STEPS_PER_POLE_PAIR);
    // Registered so the output comes straight from a flop
    st_d.closed_loop = st_q.follow | (st_q.aligned & closed_loop_req_i);

    // Following error after the window is left for longer than the timeout
    if (mode_i == dmc_pkg::MODE_STEP_DIR && closed_loop_req_i && st_q.aligned &&
        absdiff(st_q.pos, actual_pos_i) > follow_window_i) begin
      if (ms_tick && st_q.err_ms != 16'hffff) begin
        st_d.err_ms = st_q.err_ms + 16'h1;
      end
      st_d.follow_err = st_q.err_ms > follow_timeout_ms_i;
    end else begin
      st_d.err_ms = 16'h0;
      st_d.follow_err = 1'b0;
    end

    // Status word assembly per mode
    st_d.status = 16'h0;
    st_d.status[dmc_pkg::SW_LIMIT] = lim_neg_s | lim_pos_s;
    unique case (mode_i)
      dmc_pkg::MODE_CST: begin
        st_d.status[dmc_pkg::SW_SYNC] = st_q.sync;
        st_d.status[dmc_pkg::SW_FOLLOW] = st_q.follow;
      end
      dmc_pkg::MODE_STEP_DIR: st_d.status[dmc_pkg::SW_FOLLOW_ERR] = st_q.follow_err;
      dmc_pkg::MODE_AUTO_SETUP: begin
        st_d.status[dmc_pkg::SW_INDEXED] = st_q.indexed;
        st_d.status[dmc_pkg::SW_FOLLOW] = st_q.aligned;
      end
      default: st_d.status[dmc_pkg::SW_SYNC] = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state
  assign status_word_o = st_q.status;
  assign demand_pos_o = st_q.pos;
  assign torque_cmd_o = st_q.torque;
  assign closed_loop_o = st_q.closed_loop;
  assign full_steps_rev_o = st_q.fsr;
endmodule

// file: rtl/dmc_edge_sync.sv
// Two-stage synchroniser with rising edge detect
`timescale 1ns/1ps
module dmc_edge_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous input
  input wire logic async_i,
  // Synchronised level and rising edge pulse
  output logic level_o,
  output logic rise_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } dmc_sync_t;
  dmc_sync_t st_q, st_d;

  // Only the second and third stages feed the edge detector, keeping metastability off logic
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.s2;
  assign rise_o = st_q.s2 & ~st_q.s3;
endmodule

// file: rtl/dmc_link_if.sv
// Pin-level link between the step source and the drive
`timescale 1ns/1ps
interface dmc_link_if;
  logic step;
  logic dir;
  modport source (output step, output dir);
  modport drive (input step, input dir);
endinterface

// file: rtl/dmc_pkg.sv
// Shared constants for the drive mode controller and its step source
package dmc_pkg;
  // Mode-of-operation selector codes
  localparam logic [7:0] MODE_CST = 8'h0a;
  localparam logic [7:0] MODE_STEP_DIR = 8'hff;
  localparam logic [7:0] MODE_AUTO_SETUP = 8'hfe;
  // Status word bit positions
  localparam int SW_SYNC = 8;
  localparam int SW_INDEXED = 10;
  localparam int SW_LIMIT = 11;
  localparam int SW_FOLLOW = 12;
  localparam int SW_FOLLOW_ERR = 13;
  // Control word bit that starts an auto setup run
  localparam int CW_START = 4;
  // Subtype codes
  localparam logic step_dir_subtype = 1'b0;
  localparam logic dual_pulse_subtype = 1'b1;
  // Step scaling defaults: quarter step per pulse
  localparam logic [15:0] STEP_NUM_RST = 16'h0080;
  localparam logic [15:0] STEP_DEN_RST = 16'h0001;
  localparam logic [15:0] FULL_STEP = 16'h0200;
  localparam logic [7:0] STEPS_PER_POLE_PAIR = 8'h04;
  // Cycle time base: only index -3 (1 ms) is accepted
  localparam logic signed [7:0] TIME_INDEX_MS = -8'sd3;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIME_BASE_NS = 1000000;
  localparam int TIME_BASE_CYC = TIME_BASE_NS / CLK_PERIOD_NS;
  localparam int PULSE_ON_NS = 200;
  localparam int PULSE_ON_CYC = (PULSE_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_PERIOD_NS = 1000;
  localparam int PULSE_PERIOD_CYC = (PULSE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIR_SETUP_US = 35;
  localparam int DIR_SETUP_CYC = (DIR_SETUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Auto setup run length in cycles
  localparam int SETUP_RUN_CYC = 64;
endpackage

// file: rtl/dmc_source.sv
// Step source: higher-level positioning controller end of the pulse link
`timescale 1ns/1ps
module dmc_source #(
  parameter int DIR_SETUP_CYC = dmc_pkg::DIR_SETUP_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Pulse link
  dmc_link_if.source link,
  // Step request
  input wire logic subtype_i,
  input wire logic req_i,
  input wire logic up_i,
  output logic busy_o
);
  typedef enum logic [1:0] {SRC_IDLE, SRC_SETUP, SRC_HIGH, SRC_LOW} dmc_src_st_t;
  typedef struct packed {
    dmc_src_st_t st;
    logic [15:0] cnt;
    logic up;
    logic step;
    logic dir;
    logic busy;
  } dmc_src_t;
  dmc_src_t s_q, s_d;

  // Pulses paced so the 1 MHz limit, 200 ns high and 35 us direction setup hold
  always_comb begin
    s_d = s_q;
    s_d.cnt = s_q.cnt + 16'h1;
    unique case (s_q.st)
      SRC_IDLE: begin
        s_d.cnt = 16'h0;
        if (req_i) begin
          s_d.up = up_i;
          s_d.busy = 1'b1;
          if (subtype_i == dmc_pkg::step_dir_subtype && up_i != s_q.dir) begin
            s_d.dir = up_i;
            s_d.st = SRC_SETUP;
          end else begin
            s_d.st = SRC_HIGH;
            s_d.step = (subtype_i == dmc_pkg::dual_pulse_subtype) ? up_i : 1'b1;
            s_d.dir = (subtype_i == dmc_pkg::dual_pulse_subtype) ? !up_i : s_q.dir;
          end
        end
      end
      SRC_SETUP: if (s_q.cnt == 16'(DIR_SETUP_CYC - 1)) begin
        s_d.st = SRC_HIGH;
        s_d.cnt = 16'h0;
        s_d.step = 1'b1;
      end
      SRC_HIGH: if (s_q.cnt == 16'(dmc_pkg::PULSE_ON_CYC - 1)) begin
        s_d.st = SRC_LOW;
        s_d.step = 1'b0;
        if (subtype_i == dmc_pkg::dual_pulse_subtype) begin
          s_d.dir = 1'b0;
        end
      end
      SRC_LOW: if (s_q.cnt == 16'(dmc_pkg::PULSE_PERIOD_CYC - 1)) begin
        s_d.st = SRC_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.step = s_q.step;
  assign link.dir = s_q.dir;
  assign busy_o = s_q.busy;
endmodule

// file: testbench/dmc_sva.sv
// Link timing checker for the step source and drive pair
`timescale 1ns/1ps
module dmc_sva (
  // Clock, reset and subtype
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic subtype_i,
  // Link pins
  input wire logic step,
  input wire logic dir
);
  logic pulse, pulse_q, dir_q;
  logic [15:0] on_cnt_q, dir_cnt_q;
  // Either pin carries pulses in the dual pulse subtype
  assign pulse = subtype_i ? (step | dir) : step;
  // Cycles since the last pulse rise and last direction change; saturate so a quiet link never wraps
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_q <= 1'b0;
      dir_q <= 1'b0;
      on_cnt_q <= 16'hffff;
      dir_cnt_q <= 16'hffff;
    end else begin
      pulse_q <= pulse;
      dir_q <= dir;
      on_cnt_q <= (pulse && !pulse_q) ? 16'h0001 : on_cnt_q + {15'h0000, on_cnt_q != 16'hffff};
      dir_cnt_q <= (dir != dir_q) ? 16'h0001 : dir_cnt_q + {15'h0000, dir_cnt_q != 16'hffff};
    end
  end
  // Pulse shapes
  sequence s_held;
    pulse [*8];
  endsequence
  sequence s_quiet;
    !pulse [*8];
  endsequence
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  AST_ON_LEN: assert property ($fell(pulse) |-> on_cnt_q == 16'(dmc_pkg::PULSE_ON_CYC))
    else $error("pulse on time wrong");
  AST_PERIOD: assert property ($rose(pulse) |-> on_cnt_q >= 16'(dmc_pkg::PULSE_PERIOD_CYC))
    else $error("pulses too close");
  AST_ON_SEQ: assert property ($rose(pulse) |-> s_held)
    else $error("pulse dropped early");
  AST_OFF_SEQ: assert property ($fell(pulse) |-> s_quiet)
    else $error("pulse gap too short");
  AST_DIR_STABLE: assert property (!subtype_i && step |-> $stable(dir))
    else $error("direction moved during pulse");
  AST_DIR_SETUP: assert property (!subtype_i && $rose(step) |-> dir_cnt_q >= 16'(dmc_pkg::DIR_SETUP_CYC))
    else $error("step too soon after direction change");
  AST_DIR_QUIET: assert property (!subtype_i && $changed(dir) |-> !step ##1 (!step) [*8])
    else $error("step right after direction change");
  AST_ONE_PIN: assert property (subtype_i |-> !(step && dir))
    else $error("both pulse pins high");
endmodule

// file: testbench/drive_mode_cst_stepdir_autosetup_test.sv
// Self-checking bench: step source and drive joined over the pulse link
`timescale 1ns/1ps
module drive_mode_cst_stepdir_autosetup_test;
  logic clk_i = 1'b0, rst_n_i = 1'b0, subtype_i = 1'b0, req_i = 1'b0, up_i = 1'b0;
  logic busy_o, closed_loop_o, cl_req = 1'b0, torque_wr = 1'b0, index = 1'b0, lim_pos = 1'b0, lim_neg = 1'b0;
  logic [7:0] mode = 8'h00, pp = 8'h03;
  logic [15:0] cw = 16'h0000, num = 16'h0080, den = 16'h0001, mt = 16'h03e8, status_word_o, full_steps_rev_o;
  logic signed [15:0] torque = 16'sh0064, torque_cmd_o;
  logic signed [31:0] demand_pos_o;
  // Time index starts at the supported -3; feedback offset opens a following error
  logic signed [7:0] tidx = 8'shfd;
  logic signed [31:0] pos_ofs = 32'sh0;
  int miscompares = 0, comparisons = 0, cycles = 0;
  dmc_link_if dmc_link_if_inst ();
  dmc_drive #(.TIME_BASE_CYC(100)) dmc_drive_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(dmc_link_if_inst),
    .mode_i(mode), .control_word_i(cw), .subtype_i(subtype_i), .closed_loop_req_i(cl_req), .step_num_i(num),
    .step_den_i(den), .pole_pairs_i(pp), .cycle_period_i(8'h01), .time_index_i(tidx), .max_torque_i(mt),
    .torque_wr_i(torque_wr), .torque_i(torque), .actual_pos_i(demand_pos_o + pos_ofs),
    .follow_window_i(32'h00000010),
    .follow_timeout_ms_i(16'h0002), .index_i(index), .limit_neg_i(lim_neg), .limit_pos_i(lim_pos),
    .status_word_o(status_word_o), .demand_pos_o(demand_pos_o), .torque_cmd_o(torque_cmd_o),
    .closed_loop_o(closed_loop_o), .full_steps_rev_o(full_steps_rev_o));
  dmc_source dmc_source_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(dmc_link_if_inst), .subtype_i(subtype_i),
    .req_i(req_i), .up_i(up_i), .busy_o(busy_o));
  dmc_sva dmc_sva_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .subtype_i(subtype_i), .step(dmc_link_if_inst.step),
    .dir(dmc_link_if_inst.dir));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One step request; busy is looked at only after the taking edge has landed
  task automatic send(input logic up);
    int n;
    n = 0;
    req_i <= 1'b1;
    up_i <= up;
    tick(2);
    req_i <= 1'b0;
    while (busy_o !== 1'b0 && n < 5000) begin
      tick(1);
      n++;
    end
    chk(32'(busy_o), 32'h0);
    tick(8);
  endtask
  // Setpoint written every tenth clock for 25 fieldbus cycles
  task automatic feed;
    repeat (250) begin
      torque_wr <= 1'b1;
      tick(1);
      torque_wr <= 1'b0;
      tick(9);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Clock and hang guard
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      end_of_test();
    end
  end
  // Main sequence
  initial begin
    tick(6);
    rst_n_i <= 1'b1;
    mode <= dmc_pkg::MODE_STEP_DIR;
    tick(2);
    repeat (3) send(1'b1);
    chk(demand_pos_o, 32'h00000180);
    send(1'b0);
    chk(demand_pos_o, 32'h00000100);
    chk(32'(full_steps_rev_o), 32'h0000000c);
    num <= 16'h0200;
    tick(2);
    send(1'b0);
    chk(demand_pos_o, 32'hffffff00);
    num <= 16'h0100;
    den <= 16'h0002;
    tick(2);
    send(1'b0);
    chk(demand_pos_o, 32'hfffffe80);
    lim_pos <= 1'b1;
    send(1'b1);
    chk(demand_pos_o, 32'hfffffe80);
    chk(32'(status_word_o[11]), 32'h1);
    lim_pos <= 1'b0;
    lim_neg <= 1'b1;
    send(1'b0);
    chk(demand_pos_o, 32'hfffffe80);
    lim_neg <= 1'b0;
    mode <= dmc_pkg::MODE_CST;
    send(1'b1);
    chk(demand_pos_o, 32'hfffffe80);
    $display("step_dir done");
    // Bit 4 raised outside auto setup must not start a run later
    cw <= 16'h0010;
    cl_req <= 1'b1;
    tick(2);
    mode <= dmc_pkg::MODE_AUTO_SETUP;
    tick(100);
    chk(32'(status_word_o[12]), 32'h0);
    chk(32'(closed_loop_o), 32'h0);
    cw <= 16'h0000;
    tick(2);
    cw <= 16'h0010;
    tick(4);
    chk(32'(status_word_o[10]), 32'h0);
    index <= 1'b1;
    tick(5);
    index <= 1'b0;
    tick(90);
    chk(32'(status_word_o[10]), 32'h1);
    chk(32'(status_word_o[12]), 32'h1);
    chk(32'(closed_loop_o), 32'h1);
    $display("auto_setup done");
    // Every control word bit set while torque runs; none may matter
    mode <= dmc_pkg::MODE_CST;
    cw <= 16'hffff;
    feed();
    chk(32'(status_word_o[8]), 32'h1);
    chk(32'(status_word_o[12]), 32'h1);
    chk(32'(torque_cmd_o), 32'h00000064);
    // Oversized setpoint is held to the torque ceiling
    torque <= 16'sh1388;
    torque_wr <= 1'b1;
    tick(1);
    torque_wr <= 1'b0;
    tick(2);
    chk(32'(torque_cmd_o), 32'h000003e8);
    tick(300);
    chk(32'(status_word_o[8]), 32'h0);
    // Open loop, and an unsupported time index that must never report sync
    cl_req <= 1'b0;
    tidx <= 8'shfe;
    feed();
    chk(32'(status_word_o[12]), 32'h0);
    chk(32'(torque_cmd_o), 32'h0);
    chk(32'(status_word_o[8]), 32'h0);
    $display("torque done");
    // Closed loop clock-direction with the feedback held outside the window
    mode <= dmc_pkg::MODE_STEP_DIR;
    cl_req <= 1'b1;
    pos_ofs <= 32'sh00000020;
    tick(150);
    chk(32'(status_word_o[13]), 32'h0);
    tick(300);
    chk(32'(status_word_o[13]), 32'h1);
    pos_ofs <= 32'sh0;
    tick(3);
    chk(32'(status_word_o[13]), 32'h0);
    $display("follow_err done");
    // Second reset, then the dual pulse subtype
    rst_n_i <= 1'b0;
    subtype_i <= 1'b1;
    mode <= dmc_pkg::MODE_STEP_DIR;
    num <= 16'h0080;
    den <= 16'h0001;
    tick(6);
    chk(demand_pos_o, 32'h0);
    rst_n_i <= 1'b1;
    tick(2);
    send(1'b1);
    chk(demand_pos_o, 32'h00000080);
    send(1'b0);
    chk(demand_pos_o, 32'h0);
    $display("dual_pulse done");
    end_of_test();
  end
endmodule
